// ==== hw/pagio_top.v ====
// What this block does
// - Eight-bit output latch, one bit for each pin 0 to 7.
// - Pin 4 only pulls low, and its input also feeds the timer clock.
// - Pin 5 is input only and never driven.
// - Direction bit 1 turns the driver off, 0 drives the latch bit.
// - Data reads return pin levels; data writes load the latch.
// - Every data write samples pins and stores the latch; only with byte lane 0 set does it merge in selected bits.
// - Pins chosen as comparator inputs read as zero.
// - Reset sets all inputs, disables digital inputs, grounds comparator inputs.
// - Pins 6 and 7 claimed by the oscillator ignore direction and read zero.
// - Direction bits still govern drivers on comparator input pins.
// - Comparator outputs reach pins 3 and 4 only with direction bits clear.
// - Master clear on pin 5 holds the device in reset while low.
// - In resistor or internal RC mode pin 6 can give a quarter clock.
// - Comparator outputs and the clock out replace the latch; comparator inputs and the reference on pin 2 leave drivers to direction bits.
// - Comparator and reference control registers select the pin functions.
//
// Our own choice: the APB slave port.
`include "pagio_defs.vh"
`default_nettype none

module pagio_top #(
   parameter AW = 12
) (
   input  wire          CLK,          // Core clock, 40 MHz
   input  wire          RST,          // Synchronous reset, active high
   input  wire          PSEL,         // APB select
   input  wire          PENABLE,      // APB access phase
   input  wire          PWRITE,       // APB direction, high for write
   input  wire [AW-1:0] PADDR,        // APB byte address
   input  wire [31:0]   PWDATA,       // APB write data
   input  wire [3:0]    PSTRB,        // APB byte strobes
   output reg           PREADY,       // APB ready
   output reg  [31:0]   PRDATA,       // APB read data
   output reg           PSLVERR,      // APB error, unmapped address
   input  wire [7:0]    PA_IN,        // Port pin levels
   output reg  [7:0]    PA_OUT,       // Port pin drive values
   output reg  [7:0]    PA_OE,        // Port pin output enables
   input  wire [1:0]    CMP_RESULT,   // Raw comparator results, asynchronous
   input  wire [1:0]    OSC_CLAIM,    // Oscillator owns pin 6 (bit 0) and pin 7 (bit 1)
   input  wire          QUARTER_CLOCK_OUT_EN,    // Resistor or internal RC mode with clock out
   input  wire          MASTER_CLEAR_PIN_EN,      // Pin 5 acts as master clear
   output reg           T0_CLK_IN,    // Synchronised pin 4 level for timer 0
   output reg           MASTER_CLEAR_PIN_RESET,   // Device reset request from pin 5
   output reg  [3:0]    ANALOG_SEL,   // Pins 0 to 3 used as comparator inputs
   output reg           CMP_IN_GND,   // Comparator inputs tied to ground
   output reg  [5:0]    CMP_CTRL,     // Comparator control to the analog block
   output reg  [7:0]    VREF_CTRL,    // Reference control to the analog block
   output reg           VREF_ON_PIN2  // Reference voltage routed to pin 2
);

   localparam ST_IDLE = 1'b0;
   localparam ST_ACC  = 1'b1;

   reg  [7:0]  latch_r;
   reg  [7:0]  dir_r;
   reg  [5:0]  cmp_r;
   reg  [7:0]  vref_r;
   reg  [1:0]  div_r;
   reg         clkq_r;
   reg         master_clear_pin_r;
   reg         st_r;
   reg  [7:0]  latch_nxt;
   reg  [7:0]  rdata_nxt;
   reg         err_nxt;
   reg  [7:0]  out_nxt;
   reg  [7:0]  oe_nxt;
   wire [9:0]  sync_q;
   wire [7:0]  pin_s;
   wire [1:0]  cmp_s;
   wire        rst_i;
   wire [9:0]  idx;
   wire        aligned;
   wire        setup;
   wire        acc_wr;
   wire [2:0]  cm;
   wire [3:0]  ana;
   wire        c1out;
   wire        c2out;
   wire        pin_out_mode;
   wire [7:0]  pin_read;
   wire [7:0]  wmask;
   wire        wr_data;
   wire        wr_dir;
   wire        wr_cmp;
   wire        wr_vref;

   // Comparator inputs, pins 0..3, per mode and input switch
   function [3:0] analog_mask;
      input [2:0] mode;
      input       cis;
      begin
         case (mode)
            3'h0:    analog_mask = 4'hf;
            3'h1:    analog_mask = cis ? 4'hf : 4'hb;
            3'h2:    analog_mask = 4'hf;
            3'h3:    analog_mask = 4'h7;
            3'h4:    analog_mask = 4'hf;
            3'h5:    analog_mask = 4'h6;
            3'h6:    analog_mask = 4'h7;
            default: analog_mask = 4'h0;
         endcase
      end
   endfunction

   function mapped;
      input [9:0] i;
      begin
         mapped = (i == `PAGIO_IDX_DATA) || (i == `PAGIO_IDX_CMP) ||
                  (i == `PAGIO_IDX_DIR)  || (i == `PAGIO_IDX_VREF);
      end
   endfunction

   // Control registers take a write only with byte lane 0 set
   function lane0_hit;
      input [9:0] i;
      input [9:0] target;
      input       wr;
      input [3:0] strb;
      begin
         lane0_hit = wr && strb[0] && (i == target);
      end
   endfunction

   pagio_sync #(
      .W (10)
   ) u_sync (
      .CLK (CLK),
      .RST (RST),
      .D   ({CMP_RESULT, PA_IN}),
      .Q   (sync_q)
   );

   assign pin_s = sync_q[7:0];
   assign cmp_s = sync_q[9:8];

   // Master clear also resets this port, as it does the rest of the device
   assign rst_i = RST | master_clear_pin_r;

   assign idx     = PADDR[11:2];
   assign aligned = (PADDR[1:0] == 2'b00);
   assign setup   = PSEL & ~PENABLE;
   // Unmapped or unaligned accesses answer with an error and never write
   assign acc_wr  = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;

   assign cm           = cmp_r[`PAGIO_CMP_MODE_MSB:`PAGIO_CMP_MODE_LSB];
   assign ana          = analog_mask(cm, cmp_r[`PAGIO_CMP_CIS]);
   assign c1out        = cmp_s[0] ^ cmp_r[`PAGIO_CMP_C1INV];
   assign c2out        = cmp_s[1] ^ cmp_r[`PAGIO_CMP_C2INV];
   assign pin_out_mode = (cm == `PAGIO_CM_PIN_OUT);

   // Live pin levels with analog and oscillator pins masked to zero
   assign pin_read = pin_s & ~{OSC_CLAIM, 2'b00, ana};

   // Byte lane 1 selects the bits a write changes; without it all eight change
   assign wmask = PSTRB[1] ? PWDATA[15:8] : 8'hff;

   // Write strobes, one per register
   assign wr_data = acc_wr && (idx == `PAGIO_IDX_DATA);
   assign wr_dir  = lane0_hit(idx, `PAGIO_IDX_DIR, acc_wr, PSTRB);
   assign wr_cmp  = lane0_hit(idx, `PAGIO_IDX_CMP, acc_wr, PSTRB);
   assign wr_vref = lane0_hit(idx, `PAGIO_IDX_VREF, acc_wr, PSTRB);

   // A data write without lane 0 still refreshes the latch from the pins
   always @*
   begin
      latch_nxt = latch_r;
      if (wr_data && PSTRB[0])
         latch_nxt = (pin_read & ~wmask) | (PWDATA[7:0] & wmask);
      else if (wr_data)
         latch_nxt = pin_read;
   end

   always @*
   begin
      rdata_nxt = 8'h00;
      err_nxt   = ~aligned | ~mapped(idx);
      if (!err_nxt)
      begin
         case (idx)
            `PAGIO_IDX_DATA: rdata_nxt = pin_read;
            `PAGIO_IDX_CMP:  rdata_nxt = {c2out, c1out, cmp_r};
            `PAGIO_IDX_DIR:  rdata_nxt = dir_r | `PAGIO_DIR_RD_ONES;
            `PAGIO_IDX_VREF: rdata_nxt = vref_r & ~(8'h01 << `PAGIO_VR_UNUSED);
            default:         rdata_nxt = 8'h00;
         endcase
      end
   end

   // Pin drivers; peripherals are given priority over the latch
   always @*
   begin
      out_nxt = latch_r;
      oe_nxt  = ~dir_r;
      if (pin_out_mode)
      begin
         out_nxt[`PAGIO_PIN_CMP1] = c1out;
         out_nxt[`PAGIO_PIN_OD]   = c2out;
      end
      // Open drain: drive only a low, release for a high
      oe_nxt[`PAGIO_PIN_OD]  = ~dir_r[`PAGIO_PIN_OD] & ~out_nxt[`PAGIO_PIN_OD];
      out_nxt[`PAGIO_PIN_OD] = 1'b0;
      out_nxt[`PAGIO_PIN_IN_ONLY] = 1'b0;
      oe_nxt[`PAGIO_PIN_IN_ONLY]  = 1'b0;
      if (OSC_CLAIM[1])
      begin
         out_nxt[`PAGIO_PIN_OSCIN] = 1'b0;
         oe_nxt[`PAGIO_PIN_OSCIN]  = 1'b0;
      end
      // Clock output wins over the oscillator claim on pin 6
      if (QUARTER_CLOCK_OUT_EN)
      begin
         out_nxt[`PAGIO_PIN_QUARTER_CLOCK_OUT] = clkq_r;
         oe_nxt[`PAGIO_PIN_QUARTER_CLOCK_OUT]  = 1'b1;
      end
      else if (OSC_CLAIM[0])
      begin
         out_nxt[`PAGIO_PIN_QUARTER_CLOCK_OUT] = 1'b0;
         oe_nxt[`PAGIO_PIN_QUARTER_CLOCK_OUT]  = 1'b0;
      end
   end

   // Clear is taken from the synchronised level so reset never sees a metastable pin
   always @(posedge CLK)
   begin
      if (RST)
         master_clear_pin_r <= 1'b0;
      else
         master_clear_pin_r <= MASTER_CLEAR_PIN_EN & ~pin_s[`PAGIO_PIN_IN_ONLY];
   end

   // Quarter clock; runs free so pin 6 keeps toggling across register writes
   always @(posedge CLK)
   begin
      if (rst_i)
      begin
         div_r  <= 2'b00;
         clkq_r <= 1'b0;
      end
      else
      begin
         div_r  <= div_r + 2'b01;
         clkq_r <= (div_r >= (`PAGIO_QUARTER_CLOCK_OUT_DIV / 2)) ? 1'b1 : 1'b0;
      end
   end

   // Port latch and control registers
   always @(posedge CLK)
   begin
      if (rst_i)
      begin
         latch_r <= `PAGIO_RST_DATA;
         dir_r   <= `PAGIO_RST_DIR;
         cmp_r   <= `PAGIO_RST_CMP;
         vref_r  <= `PAGIO_RST_VREF;
      end
      else
      begin
         latch_r <= latch_nxt;
         if (wr_dir)
            dir_r <= PWDATA[7:0];
         if (wr_cmp)
            cmp_r <= PWDATA[5:0];
         if (wr_vref)
            vref_r <= PWDATA[7:0] & ~(8'h01 << `PAGIO_VR_UNUSED);
      end
   end

   // APB slave: one wait-free access phase, read data captured in setup
   always @(posedge CLK)
   begin
      if (rst_i)
      begin
         st_r    <= ST_IDLE;
         PREADY  <= 1'b0;
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end
      else
      begin
         case (st_r)
            ST_IDLE:
            begin
               if (setup)
               begin
                  st_r    <= ST_ACC;
                  PREADY  <= 1'b1;
                  PSLVERR <= err_nxt;
                  PRDATA  <= PWRITE ? 32'h0000_0000 : {24'h00_0000, rdata_nxt};
               end
               else
               begin
                  PREADY  <= 1'b0;
                  PSLVERR <= 1'b0;
               end
            end
            ST_ACC:
            begin
               st_r    <= ST_IDLE;
               PREADY  <= 1'b0;
               PSLVERR <= 1'b0;
            end
            default:
            begin
               st_r    <= ST_IDLE;
               PREADY  <= 1'b0;
               PSLVERR <= 1'b0;
            end
         endcase
      end
   end

   // Registered pin and side outputs
   always @(posedge CLK)
   begin
      if (RST)
      begin
         PA_OUT       <= 8'h00;
         PA_OE        <= 8'h00;
         T0_CLK_IN    <= 1'b0;
         MASTER_CLEAR_PIN_RESET   <= 1'b0;
         ANALOG_SEL   <= 4'hf;
         CMP_IN_GND   <= 1'b1;
         CMP_CTRL     <= `PAGIO_RST_CMP;
         VREF_CTRL    <= `PAGIO_RST_VREF;
         VREF_ON_PIN2 <= 1'b0;
      end
      else
      begin
         PA_OUT       <= out_nxt;
         PA_OE        <= oe_nxt;
         // Timer input is already synchronised; the timer needs no stage of its own
         T0_CLK_IN    <= pin_s[`PAGIO_PIN_OD];
         MASTER_CLEAR_PIN_RESET   <= master_clear_pin_r;
         ANALOG_SEL   <= ana;
         CMP_IN_GND   <= (cm == `PAGIO_CM_RESET);
         CMP_CTRL     <= cmp_r;
         VREF_CTRL    <= vref_r;
         // Driver on pin 2 is left to the direction bit; software keeps it an input
         VREF_ON_PIN2 <= vref_r[`PAGIO_VR_EN] & vref_r[`PAGIO_VR_OE];
      end
   end

endmodule

`default_nettype wire

// ==== hw/pagio_defs.vh ====
`ifndef PAGIO_DEFS_VH
`define PAGIO_DEFS_VH

// Register indices; byte address is four times the index
`define PAGIO_IDX_DATA      10'h005
`define PAGIO_IDX_CMP       10'h01f
`define PAGIO_IDX_DIR       10'h085
`define PAGIO_IDX_VREF      10'h09f

// Reset values
`define PAGIO_RST_DATA      8'h00
`define PAGIO_RST_DIR       8'hff
`define PAGIO_RST_CMP       6'h00
`define PAGIO_RST_VREF      8'h00

// Pin positions
`define PAGIO_PIN_VREF      2
`define PAGIO_PIN_CMP1      3
`define PAGIO_PIN_OD        4
`define PAGIO_PIN_IN_ONLY   5
`define PAGIO_PIN_QUARTER_CLOCK_OUT    6
`define PAGIO_PIN_OSCIN     7

// Comparator control fields
`define PAGIO_CMP_MODE_LSB  0
`define PAGIO_CMP_MODE_MSB  2
`define PAGIO_CMP_CIS       3
`define PAGIO_CMP_C1INV     4
`define PAGIO_CMP_C2INV     5
`define PAGIO_CMP_C1OUT     6
`define PAGIO_CMP_C2OUT     7

// Comparator modes with a special pin use
`define PAGIO_CM_RESET      3'h0
`define PAGIO_CM_PIN_OUT    3'h6
`define PAGIO_CM_OFF        3'h7

// Reference control fields
`define PAGIO_VR_EN         7
`define PAGIO_VR_OE         6
`define PAGIO_VR_UNUSED     4

// Direction bit 5 always reads as input
`define PAGIO_DIR_RD_ONES   8'h20

// Clock output divides the core clock by four
`define PAGIO_QUARTER_CLOCK_OUT_DIV    4

`endif

// ==== hw/pagio_sync.v ====
`default_nettype none

module pagio_sync #(
   parameter W = 8
) (
   input  wire         CLK,  // Core clock
   input  wire         RST,  // Synchronous reset, active high
   input  wire [W-1:0] D,    // Asynchronous levels
   output reg  [W-1:0] Q     // Synchronised levels
);

   reg [W-1:0] meta_r;

   // First stage feeds only the second
   always @(posedge CLK)
   begin
      if (RST)
      begin
         meta_r <= {W{1'b0}};
         Q      <= {W{1'b0}};
      end
      else
      begin
         meta_r <= D;
         Q      <= meta_r;
      end
   end

endmodule

`default_nettype wire

// ==== tb/pagio_properties.sv ====
`include "pagio_defs.vh"
`default_nettype none
module pagio_props #(
   parameter AW = 12
) (
   input wire logic          CLK,        // Clock
   input wire logic          RST,        // Reset
   input wire logic          PSEL,       // Select
   input wire logic          PENABLE,    // Access
   input wire logic          PWRITE,     // Write
   input wire logic [AW-1:0] PADDR,      // Address
   input wire logic [31:0]   PWDATA,     // Write data
   input wire logic [3:0]    PSTRB,      // Strobes
   input wire logic          PREADY,     // Ready
   input wire logic [31:0]   PRDATA,     // Read data
   input wire logic [7:0]    PA_IN,      // Pins
   input wire logic [7:0]    PA_OUT,     // Drive
   input wire logic [7:0]    PA_OE,      // Enables
   input wire logic [1:0]    OSC_CLAIM,  // Claims
   input wire logic          QUARTER_CLOCK_OUT_EN,  // Clock out
   input wire logic          MASTER_CLEAR_PIN_EN,    // Clear on
   input wire logic          MASTER_CLEAR_PIN_RESET, // Clear request
   input wire logic          T0_CLK_IN,  // Timer input
   input wire logic [3:0]    ANALOG_SEL, // Analog pins
   input wire logic          CMP_IN_GND  // Grounded
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_wr(a);
      PSEL && PENABLE && PREADY && PWRITE && PSTRB[0] && PADDR == a;
   endsequence
   a_ready_once: assert property (s_setup |=> PREADY ##1 !PREADY)
      else $error("ready not single");
   a_pin5_undriven: assert property (!PA_OE[5])
      else $error("pin5 driven");
   a_pin4_sink: assert property (!PA_OUT[4])
      else $error("pin4 drives high");
   a_timer_in: assert property ($stable(PA_IN[4])[*5] |-> T0_CLK_IN == PA_IN[4])
      else $error("timer input stale");
   a_dir_drive: assert property (s_wr({`PAGIO_IDX_DIR, 2'b00})
      |-> ##2 PA_OE[1:0] == ~$past(PWDATA[1:0], 2)) else $error("enable not from dir");
   a_latch_drive: assert property (s_wr({`PAGIO_IDX_DATA, 2'b00}) ##0 PSTRB[1]
      && PWDATA[9:8] == 2'b11 |-> ##2 ((PA_OUT[1:0] ^ $past(PWDATA[1:0], 2)) & PA_OE[1:0]) == 0)
      else $error("latch not driven");
   a_read_mask: assert property (PREADY && !PWRITE && PADDR == {`PAGIO_IDX_DATA, 2'b00}
      |-> (PRDATA[3:0] & ANALOG_SEL) == 0 && !(OSC_CLAIM[1] && PRDATA[7]) && PRDATA[31:8] == 0)
      else $error("masked pin reads high");
   a_pin7_claim: assert property (OSC_CLAIM[1] && $past(OSC_CLAIM[1]) |-> !PA_OE[7])
      else $error("claimed pin driven");
   a_reset_state: assert property ($past(RST) |-> PA_OE == 0 && ANALOG_SEL == 4'hf && CMP_IN_GND)
      else $error("reset state wrong");
   a_clear_hold: assert property (($stable(PA_IN[5]) && $stable(MASTER_CLEAR_PIN_EN))[*5]
      |-> MASTER_CLEAR_PIN_RESET == (MASTER_CLEAR_PIN_EN && !PA_IN[5])) else $error("clear request wrong");
   a_quarter_clock_out_div: assert property (QUARTER_CLOCK_OUT_EN[*8] |-> PA_OE[6] && PA_OUT[6] != $past(PA_OUT[6], 2))
      else $error("clock out not quarter rate");
endmodule
bind pagio_top pagio_props #(.AW(AW)) u_props (.*);
`default_nettype wire

// ==== tb/pagio_pins.sv ====
`default_nettype none
module pagio_pins (
   input  wire logic [7:0] pa_out, // Device drive values
   input  wire logic [7:0] pa_oe,  // Device drive enables
   input  wire logic [7:0] ext,    // Board drive values
   input  wire logic [7:0] ext_en, // Board drive enables
   input  wire logic       clk,    // Core clock
   output var  logic [7:0] pa_in   // Pin levels
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] last_r;
   always @(posedge clk) last_r <= pa_in;
   // Pin 4 only sinks; a floating pin wanders so a stale level cannot pass
   always_comb
      for (int i = 0; i < 8; i++)
         pa_in[i] = pa_oe[i] ? (i == 4 ? 1'b0 : pa_out[i]) : ext_en[i] ? ext[i] : ~last_r[i];
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
`include "pagio_defs.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [11:0] A_DAT = {`PAGIO_IDX_DATA, 2'b00};
   localparam logic [11:0] A_CMP = {`PAGIO_IDX_CMP, 2'b00};
   localparam logic [11:0] A_DIR = {`PAGIO_IDX_DIR, 2'b00};
   localparam logic [11:0] A_VR  = {`PAGIO_IDX_VREF, 2'b00};
   // Analog pins 3..0 for each comparator mode, input switch clear
   localparam logic [3:0]  AM [8] = '{4'hf, 4'hb, 4'hf, 4'h7, 4'hf, 4'h6, 4'h7, 4'h0};
   logic        CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic        QUARTER_CLOCK_OUT_EN = 1'b0, MASTER_CLEAR_PIN_EN = 1'b0, err;
   logic        PREADY, PSLVERR, T0_CLK_IN, MASTER_CLEAR_PIN_RESET, CMP_IN_GND, VREF_ON_PIN2;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0000_0000, PRDATA, r, d;
   logic [3:0]  PSTRB = 4'h0, ANALOG_SEL, st;
   logic [1:0]  OSC_CLAIM = 2'h0, CMP_RESULT = 2'h0;
   logic [7:0]  PA_IN, PA_OUT, PA_OE, VREF_CTRL, ext = 8'h00, lat, dir, cmp, p;
   logic [5:0]  CMP_CTRL;
   int          n_mismatch = 0, tests_run = 0;
   pagio_top uut (.*);
   pagio_pins board (.pa_out(PA_OUT), .pa_oe(PA_OE), .ext(ext), .ext_en(~PA_OE), .clk(CLK),
                     .pa_in(PA_IN));
   always #12.5 CLK = ~CLK;
   function automatic logic [7:0] oe_m();
      logic [7:0] o;
      o = ~dir & 8'hdf;
      o[4] = ~dir[4] & ~lat[4];
      o[7] = o[7] & ~OSC_CLAIM[1];
      o[6] = QUARTER_CLOCK_OUT_EN | (o[6] & ~OSC_CLAIM[0]);
      return o;
   endfunction
   function automatic logic [7:0] pin_m();
      return (oe_m() & lat) | (~oe_m() & ext);
   endfunction
   function automatic logic [7:0] rd_m();
      return pin_m() & ~{OSC_CLAIM, 2'b00, AM[cmp[2:0]]};
   endfunction
   task automatic wrap_up();
      if (n_mismatch == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("mismatch at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dd,
                      input logic [3:0] s);
      int n;
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= dd;
      PSTRB <= s;
      @(posedge CLK);
      PENABLE <= 1'b1;
      n = 0;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (PREADY !== 1'b1 && n < 16);
      r = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLK);
      if (n == 16)
      begin
         n_mismatch++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] dd, input logic [3:0] s);
      apb(1'b1, a, dd, s);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(r, {24'h0, e});
   endtask
   initial
   begin
      void'($urandom(32'h058d722b));
      repeat (10) @(posedge CLK);
      RST <= 1'b0;
      lat = 8'h00;
      dir = 8'hff;
      cmp = 8'h00;
      rd(A_DIR, 8'hff);
      rd(A_CMP, 8'h00);
      rd(A_VR, 8'h00);
      rd(12'h100, 8'h00);
      chk(err, 1'b1);
      cmp = 8'h07;
      wr(A_CMP, cmp, 4'h1);
      for (int i = 0; i < 24; i++)
      begin
         ext <= 8'($urandom);
         dir = 8'($urandom);
         wr(A_DIR, dir, 4'h1);
         d = $urandom;
         st = {2'b00, d[16], 1'b1};
         repeat (4) @(posedge CLK);
         p = rd_m();
         // Unselected bits keep what the pins showed, not the old latch
         lat = st[1] ? (d[7:0] & d[15:8]) | (p & ~d[15:8]) : d[7:0];
         wr(A_DAT, d, st);
         repeat (4) @(posedge CLK);
         p = pin_m();
         chk(PA_OE, oe_m());
         chk(PA_OUT & PA_OE, lat & oe_m() & 8'hef);
         chk(T0_CLK_IN, p[4]);
         rd(A_DAT, rd_m());
      end
      dir = 8'hff;
      wr(A_DIR, dir, 4'h1);
      for (int m = 0; m < 8; m++)
      begin
         CMP_RESULT <= 2'($urandom);
         cmp = {2'b00, 2'($urandom), 1'b0, 3'(m)};
         wr(A_CMP, cmp, 4'h1);
         repeat (4) @(posedge CLK);
         rd(A_CMP, {CMP_RESULT ^ cmp[5:4], cmp[5:0]});
         rd(A_DAT, rd_m());
         chk(ANALOG_SEL, AM[m]);
         chk(CMP_IN_GND, m == 0);
         chk(CMP_CTRL, cmp[5:0]);
      end
      cmp = 8'h06;
      wr(A_CMP, cmp, 4'h1);
      dir = 8'he7;
      wr(A_DIR, dir, 4'h1);
      repeat (4) @(posedge CLK);
      chk({PA_OE[4:3], PA_OUT[3]}, {~CMP_RESULT[1], 1'b1, CMP_RESULT[0]});
      dir = 8'hff;
      wr(A_DIR, dir, 4'h1);
      wr(A_VR, 8'hff, 4'h1);
      wr(A_VR, 8'h00, 4'h0);
      rd(A_VR, 8'hef);
      chk(VREF_ON_PIN2, 1'b1);
      chk(VREF_CTRL, 8'hef);
      cmp = 8'h07;
      wr(A_CMP, cmp, 4'h1);
      OSC_CLAIM <= 2'h3;
      dir = 8'h00;
      wr(A_DIR, dir, 4'h1);
      repeat (4) @(posedge CLK);
      chk(PA_OE, oe_m());
      rd(A_DAT, rd_m());
      QUARTER_CLOCK_OUT_EN <= 1'b1;
      repeat (12) @(posedge CLK);
      chk(PA_OE[6], 1'b1);
      QUARTER_CLOCK_OUT_EN <= 1'b0;
      OSC_CLAIM <= 2'h0;
      MASTER_CLEAR_PIN_EN <= 1'b1;
      ext <= 8'h00;
      repeat (6) @(posedge CLK);
      chk(MASTER_CLEAR_PIN_RESET, 1'b1);
      ext <= 8'hff;
      repeat (6) @(posedge CLK);
      chk(MASTER_CLEAR_PIN_RESET, 1'b0);
      MASTER_CLEAR_PIN_EN <= 1'b0;
      rd(A_DIR, 8'hff);
      wrap_up();
   end
endmodule
`default_nettype wire
